/* rtl/conditional_branch_unit.sv */
/*
  Conditional branch unit: decodes a branch word, reads the two source
  registers, compares them and resolves taken, target, next address,
  flush and the misaligned-target exception.
  Assumes the fetch/decode pipeline presents one instruction with its
  address under issue_valid and honours flush, next_pc and fault outputs.
*/
`include "branch_unit_regs.svh"

module conditional_branch_unit #(
  parameter bit HAS_COMPRESSED = 1'b0
) (
  input  wire logic                ref_clk,        // Core clock, 40 MHz
  input  wire logic                rst,            // Synchronous reset, active high
  input  wire logic                issue_valid,    // Instruction presented this cycle
  input  wire logic [`XLEN-1:0]    issue_insn,     // Instruction word
  input  wire logic [`XLEN-1:0]    issue_pc,       // Instruction address
  input  wire logic                wb_en,          // Register write strobe
  input  wire logic [4:0]          wb_addr,        // Register write index
  input  wire logic [`XLEN-1:0]    wb_data,        // Register write value
  input  wire logic                fetch_fault,    // Fetch fault on the instruction at fetch_fault_pc
  input  wire logic [`XLEN-1:0]    fetch_fault_pc, // Address that faulted
  output logic                     resolve_valid,  // Branch resolved, one cycle
  output logic                     taken,          // Branch taken
  output logic [`XLEN-1:0]         target,         // Target when taken, else zero
  output logic [`XLEN-1:0]         next_pc,        // Address to fetch next
  output logic                     flush,          // Discard younger instruction
  output logic                     misaligned_exc, // Target misaligned exception
  output logic                     target_fault    // Fetch fault belongs to target
);

  // ----------------------------------------------------------------
  // Decode stage
  // ----------------------------------------------------------------
  logic                       is_branch;
  logic [12:0]                offset;
  logic [`XLEN-1:0]           offset_ext;
  branch_pkg::minor_opcode_field_t minor;
  logic [4:0]                 first_source_register;
  logic [4:0]                 second_source_register;

  assign is_branch = issue_valid &&
                     (issue_insn[`OPC_HI:`OPC_LO] == `OPC_BRANCH) &&
                     (issue_insn[`MINOR_HI:`MINOR_LO] != 3'h2) &&
                     (issue_insn[`MINOR_HI:`MINOR_LO] != 3'h3);
  assign offset = {issue_insn[`IMM_HI_TOP], issue_insn[`IMM_LO_BIT11],
                   issue_insn[`IMM_HI_BIT10:`IMM_HI_BIT5],
                   issue_insn[`IMM_LO_BIT4:`IMM_LO_BIT1], 1'b0};
  assign offset_ext = {{(`XLEN-13){offset[12]}}, offset};
  assign minor = branch_pkg::minor_opcode_field_t'(issue_insn[`MINOR_HI:`MINOR_LO]);
  assign first_source_register  = issue_insn[`SRC1_HI:`SRC1_LO];
  assign second_source_register = issue_insn[`SRC2_HI:`SRC2_LO];

  // ----------------------------------------------------------------
  // Operand read, one cycle
  // ----------------------------------------------------------------
  logic [`XLEN-1:0] src_a;
  logic [`XLEN-1:0] src_b;
  logic             take;

  reg_file_mem #(.DW(`XLEN), .AW(5)) u_regs (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .wr_en     (wb_en),
    .wr_addr   (wb_addr),
    .wr_data   (wb_data),
    .rd_addr_a (first_source_register),
    .rd_addr_b (second_source_register),
    .rd_data_a (src_a),
    .rd_data_b (src_b)
  );

  logic                            ex_valid_q;
  branch_pkg::minor_opcode_field_t ex_minor_q;
  logic [`XLEN-1:0]                ex_pc_q;
  logic [`XLEN-1:0]                ex_target_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ex_valid_q  <= 1'b0;
      ex_minor_q  <= branch_pkg::branch_if_equal;
      ex_pc_q     <= '0;
      ex_target_q <= '0;
    end else begin
      // Kill the shadow instruction behind a taken branch and the one issued under flush
      ex_valid_q  <= is_branch && !take && !flush;
      ex_minor_q  <= minor;
      ex_pc_q     <= issue_pc;
      ex_target_q <= issue_pc + offset_ext;
    end
  end

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  logic cond;

  always_comb begin
    unique case (ex_minor_q)
      branch_pkg::branch_if_equal:                  cond = (src_a == src_b);
      branch_pkg::branch_if_not_equal:              cond = (src_a != src_b);
      branch_pkg::branch_if_less_signed:            cond = ($signed(src_a) <  $signed(src_b));
      branch_pkg::branch_if_less_unsigned:          cond = (src_a <  src_b);
      branch_pkg::branch_if_greater_equal_signed:   cond = ($signed(src_a) >= $signed(src_b));
      branch_pkg::branch_if_greater_equal_unsigned: cond = (src_a >= src_b);
      default:                                      cond = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Resolve
  // ----------------------------------------------------------------
  logic mis;

  assign take = ex_valid_q && cond;
  assign mis  = take && !HAS_COMPRESSED && (ex_target_q[1:0] != 2'b00);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resolve_valid  <= 1'b0;
      taken          <= 1'b0;
      target         <= '0;
      next_pc        <= '0;
      flush          <= 1'b0;
      misaligned_exc <= 1'b0;
    end else begin
      resolve_valid  <= ex_valid_q;
      taken          <= take;
      target         <= take ? ex_target_q : '0;
      next_pc        <= take ? ex_target_q : ex_pc_q + `INSN_STEP;
      flush          <= take;
      misaligned_exc <= mis;
    end
  end

  // ----------------------------------------------------------------
  // Fault attribution
  // ----------------------------------------------------------------
  logic [`XLEN-1:0] last_target_q;
  logic             last_target_ok_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_target_q    <= '0;
      last_target_ok_q <= 1'b0;
      target_fault     <= 1'b0;
    end else begin
      if (take && !mis) begin
        last_target_q    <= ex_target_q;
        last_target_ok_q <= 1'b1;
      end
      target_fault <= fetch_fault && last_target_ok_q && (fetch_fault_pc == last_target_q);
    end
  end

endmodule

/* rtl/branch_unit_regs.svh */
/*
  Constants for the conditional branch unit: instruction field positions,
  branch opcode, instruction step and widths.
  Assumes inclusion by bare name from rtl/.
*/
`ifndef BRANCH_UNIT_REGS_SVH
`define BRANCH_UNIT_REGS_SVH

`define XLEN              32
`define OPC_HI            6
`define OPC_LO            0
`define MINOR_HI          14
`define MINOR_LO          12
`define SRC1_HI           19
`define SRC1_LO           15
`define SRC2_HI           24
`define SRC2_LO           20
`define IMM_HI_TOP        31
`define IMM_HI_BIT10      30
`define IMM_HI_BIT5       25
`define IMM_LO_BIT4       11
`define IMM_LO_BIT1       8
`define IMM_LO_BIT11      7
`define OPC_BRANCH        7'h63
`define INSN_STEP         32'h0000_0004
`define REG_COUNT         32

`endif

/* rtl/branch_pkg.sv */
/*
  Types for the conditional branch unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package branch_pkg;

  typedef enum logic [2:0] {
    branch_if_equal                  = 3'b000,
    branch_if_not_equal              = 3'b001,
    cond_rsv2                        = 3'b010,
    cond_rsv3                        = 3'b011,
    branch_if_less_signed            = 3'b100,
    branch_if_greater_equal_signed   = 3'b101,
    branch_if_less_unsigned          = 3'b110,
    branch_if_greater_equal_unsigned = 3'b111
  } minor_opcode_field_t;

endpackage

/* rtl/reg_file_mem.sv */
/*
  Small register file used to hold the source operands the branch compares.
  Two registered read ports, one write port; entry zero reads as zero.
  Assumes a single clock and a synchronous active-high reset.
*/
module reg_file_mem #(
  parameter int DW = 32,
  parameter int AW = 5
) (
  input  wire logic          ref_clk,   // Core clock
  input  wire logic          rst,       // Synchronous reset
  input  wire logic          wr_en,     // Write strobe
  input  wire logic [AW-1:0] wr_addr,   // Write index
  input  wire logic [DW-1:0] wr_data,   // Write value
  input  wire logic [AW-1:0] rd_addr_a, // Read index A
  input  wire logic [AW-1:0] rd_addr_b, // Read index B
  output logic      [DW-1:0] rd_data_a, // Registered read A
  output logic      [DW-1:0] rd_data_b  // Registered read B
);

  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge ref_clk) begin
    if (wr_en && wr_addr != '0) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_a <= '0;
      rd_data_b <= '0;
    end else begin
      rd_data_a <= (rd_addr_a == '0) ? '0 : mem_q[rd_addr_a];
      rd_data_b <= (rd_addr_b == '0) ? '0 : mem_q[rd_addr_b];
    end
  end

endmodule

/* sim/cbu_props.sv */
/* Port checker for the conditional branch unit.
   Bound into every conditional_branch_unit instance. */
module cbu_props #(
  parameter bit HAS_COMPRESSED = 1'b0
) (
  input wire logic        ref_clk, rst, issue_valid, fetch_fault, // Clock, reset, strobes
  input wire logic [31:0] issue_insn, issue_pc, target, next_pc,  // Words
  input wire logic        resolve_valid, taken, flush,            // Results
  input wire logic        misaligned_exc, target_fault            // Exceptions
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic        br;
  logic [31:0] off;
  assign br  = issue_valid && issue_insn[6:0] == 7'h63 && issue_insn[14:13] != 2'b01 && !flush;
  assign off = {{19{issue_insn[31]}}, issue_insn[31], issue_insn[7], issue_insn[30:25], issue_insn[11:8], 1'b0};
  property p_go; br ##1 !taken |-> ##1 resolve_valid; endproperty
  a_go: assert property (p_go) else $error("branch not resolved");
  property p_shadow; br ##1 taken |-> ##1 !resolve_valid; endproperty
  a_shadow: assert property (p_shadow) else $error("shadow branch resolved");
  property p_drop; issue_valid && issue_insn[6:0] != 7'h63 |-> ##2 !resolve_valid; endproperty
  a_drop: assert property (p_drop) else $error("non-branch resolved");
  property p_tgt; resolve_valid && taken |-> target == $past(issue_pc, 2) + $past(off, 2); endproperty
  a_tgt: assert property (p_tgt) else $error("wrong target");
  property p_nt; resolve_valid && !taken |-> target == 0 && next_pc == $past(issue_pc, 2) + 32'h4; endproperty
  a_nt: assert property (p_nt) else $error("wrong fall-through");
  property p_nx; resolve_valid && taken |-> next_pc == target && flush; endproperty
  a_nx: assert property (p_nx) else $error("taken without redirect");
  property p_mis; resolve_valid && taken |-> misaligned_exc == (target[1:0] != 2'h0 && !HAS_COMPRESSED); endproperty
  a_mis: assert property (p_mis) else $error("wrong misaligned flag");
  property p_nomis; !(resolve_valid && taken) |-> !misaligned_exc; endproperty
  a_nomis: assert property (p_nomis) else $error("misaligned without taken");
  property p_idle; !resolve_valid |-> !taken && !flush; endproperty
  a_idle: assert property (p_idle) else $error("result without resolve");
  property p_flt; target_fault |-> $past(fetch_fault); endproperty
  a_flt: assert property (p_flt) else $error("target fault without fetch fault");
endmodule

bind conditional_branch_unit cbu_props #(.HAS_COMPRESSED(HAS_COMPRESSED)) u_props (.*);

/* sim/fetch_model.sv */
/* Fetch side model: reports a fetch fault while asked to.
   Driven by tb_top off the falling edge. */
module fetch_model (
  input  wire logic        fault_req,     // Raise a fault
  input  wire logic [31:0] fault_addr,    // Faulting address
  output logic             fetch_fault,   // Fault strobe
  output logic      [31:0] fetch_fault_pc // Address, scrambled when idle
);
  timeunit 1ns;
  timeprecision 1ps;
  assign fetch_fault    = fault_req;
  assign fetch_fault_pc = fault_req ? fault_addr : ~fault_addr;
endmodule

/* sim/tb_top.sv */
/* Bench for the conditional branch unit with a reference model.
   Assumes rtl/ on the include path. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0, rst = 1, iv = 0, wb_en = 0, fq = 0, ff, rv, taken, flush, mis, tf, lgv = 0, mis_c;
  logic [31:0] insn = 0, pc = 0, wb_data = 0, fa = 0, ffpc, target, next_pc, lg, a, b;
  logic [4:0]  wb_addr = 0;
  logic [2:0]  fs[6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  int          num_errors = 0, checks = 0;
  initial forever #12.5 ref_clk = ~ref_clk;
  conditional_branch_unit DUT (.ref_clk(ref_clk), .rst(rst), .issue_valid(iv), .issue_insn(insn), .issue_pc(pc),
    .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data), .fetch_fault(ff), .fetch_fault_pc(ffpc),
    .resolve_valid(rv), .taken(taken), .target(target), .next_pc(next_pc), .flush(flush),
    .misaligned_exc(mis), .target_fault(tf));
  fetch_model u_fetch (.fault_req(fq), .fault_addr(fa), .fetch_fault(ff), .fetch_fault_pc(ffpc));
  // Same stimulus with 16-bit aligned instructions supported
  conditional_branch_unit #(.HAS_COMPRESSED(1'b1)) DUT_C (.ref_clk(ref_clk), .rst(rst), .issue_valid(iv),
    .issue_insn(insn), .issue_pc(pc), .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data), .fetch_fault(ff),
    .fetch_fault_pc(ffpc), .resolve_valid(), .taken(), .target(), .next_pc(), .flush(),
    .misaligned_exc(mis_c), .target_fault());
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic issue(logic [31:0] w, output bit got);
    insn = w;
    iv = 1;
    @(negedge ref_clk);
    iv = 0;
    got = 0;
    for (int i = 0; i < 4 && !got; i++) begin
      @(negedge ref_clk);
      got = (rv === 1'b1);
    end
  endtask
  task automatic wr(logic [4:0] ad, logic [31:0] d);
    wb_en = 1;
    wb_addr = ad;
    wb_data = d;
    @(negedge ref_clk);
  endtask
  task automatic br(logic [2:0] f, logic [12:0] o, logic [31:0] p, bit drop_next);
    bit got, t;
    logic [31:0] tg, en;
    wr(5'h03, a);
    wr(5'h11, b);
    wb_en = 0;
    case (f)
      3'h0: t = a == b;
      3'h1: t = a != b;
      3'h4: t = int'(a) < int'(b);
      3'h5: t = int'(a) >= int'(b);
      3'h6: t = a < b;
      default: t = a >= b;
    endcase
    tg = p + {{19{o[12]}}, o};
    en = t ? tg : p + 32'h4;
    pc = p;
    issue({o[12], o[10:5], 5'h11, 5'h03, f, o[4:1], o[11], 7'h63}, got);
    chk("resolve", got, 1);
    if (!got) complete_run;
    chk("taken", taken, t);
    chk("target", target, t ? tg : 0);
    chk("next_pc", next_pc, en);
    chk("flush", flush, t);
    chk("misaligned", mis, t && tg[1:0] != 0);
    chk("misaligned compressed", mis_c, 0);
    if (t && tg[1:0] == 0) begin
      lg = tg;
      lgv = 1;
    end
    if (drop_next) begin
      issue(insn, got);
      chk("flushed issue", got, 0);
    end else begin
      fa = en;
      fq = 1;
      @(negedge ref_clk);
      chk("target_fault", tf, lgv && en == lg);
      fq = 0;
    end
  endtask
  initial begin
    bit got;
    void'($urandom(80074));
    repeat (8) @(negedge ref_clk);
    rst = 0;
    issue(32'h0000_0013, got);
    chk("non-branch", got, 0);
    issue(32'h0000_2063, got);
    chk("reserved minor", got, 0);
    $display("test refuse done");
    foreach (fs[k])
      for (int j = 0; j < 12; j++) begin
        a = $urandom;
        b = j % 3 == 0 ? a : (j % 3 == 1 ? ~a : $urandom);
        br(fs[k], j == 0 ? 13'h1000 : (j == 1 ? 13'h0ffe : 13'($urandom) & 13'h1ffe), $urandom & 32'hffff_fffc, 0);
      end
    $display("test compare done");
    a = 32'h5;
    b = 32'h5;
    br(3'h0, 13'h0008, 32'h0000_0100, 1);
    // Back-to-back taken branch: the second one sits in the shadow
    iv = 1;
    @(negedge ref_clk);
    @(negedge ref_clk);
    iv = 0;
    chk("shadow first", rv, 1);
    @(negedge ref_clk);
    chk("shadow second", rv, 0);
    $display("test flush done");
    complete_run;
  end
endmodule
